//--- dv/cio_board.sv
`default_nettype none
module cio_board (
  input  wire logic        core_clk_i,
  input  wire logic [39:0] pd_i,
  input  wire logic [39:0] pu_i,
  input  wire logic [39:0] ext_en_i,
  input  wire logic [39:0] ext_val_i,
  output logic      [39:0] lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [39:0] flt_q = '0;
  // undriven pins wander every cycle
  always @(posedge core_clk_i) flt_q <= ~flt_q;
  assign lvl_o = ~pd_i & ((ext_en_i & ext_val_i) | (~ext_en_i & (pu_i | flt_q)));
endmodule // cio_board
`default_nettype wire

//--- dv/cio_port_asserts.sv
`include "cio_consts.vh"
`default_nettype none
module cio_port_asserts (
  input wire logic                   core_clk_i,
  input wire logic                   rst_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pready_o,
  input wire logic [`CIO_NPIN-1:0]   pad_in_i,
  input wire logic [`CIO_NPIN-1:0]   pad_pd_o,
  input wire logic [`CIO_NPIN-1:0]   pad_spu_o,
  input wire logic [`CIO_NPIN-1:0]   pad_wpu_o,
  input wire logic [`CIO_NPIN-1:0]   pad_vwpu_o,
  input wire logic [`CIO_NPIN-1:0]   pad_ibuf_en_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // settle counter after reset
  // ----------------------------------------
  logic [1:0] settle_q;
  logic [1:0] settle_d;
  assign settle_d = (settle_q == 2'h3) ? settle_q : settle_q + 2'h1;
  always_ff @(posedge core_clk_i) begin
    if (rst_i) settle_q <= 2'h0;
    else settle_q <= settle_d;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_pd_spu_excl: assert property ((pad_pd_o & pad_spu_o) == '0)
    else $error("pull-down and strong pull-up together");
  a_pd_vwpu_excl: assert property ((pad_pd_o & pad_vwpu_o) == '0)
    else $error("pull-down and very weak pull-up together");
  a_wpu_needs_vwpu: assert property ((pad_wpu_o & ~pad_vwpu_o) == '0)
    else $error("weak pull-up without very weak pull-up");
  a_wpu_pin_low: assert property ((pad_wpu_o & ~($past(pad_in_i, 1) | $past(pad_in_i, 2)
    | $past(pad_in_i, 3) | $past(pad_in_i, 4))) == '0)
    else $error("weak pull-up on a low pin");
  a_four_quasi: assert property (settle_q == 2'h3 |-> (pad_pd_o[37:32] ^ pad_vwpu_o[37:32]) == 6'h3f)
    else $error("port four not quasi");
  a_spu_one_cycle: assert property (settle_q == 2'h3 && pad_spu_o[37:32] != 6'h0
    |=> (pad_spu_o[37:32] & $past(pad_spu_o[37:32])) == 6'h0)
    else $error("strong pull-up longer than one cycle");
  a_spu_after_pd: assert property (settle_q == 2'h3
    |-> (pad_spu_o[37:32] & ~$past(pad_spu_o[37:32]) & ~$past(pad_pd_o[37:32])) == 6'h0)
    else $error("strong pull-up without prior low");
  a_ibuf_keep: assert property ((pad_ibuf_en_o & 40'hc0_0c00_0000) == 40'hc0_0c00_0000)
    else $error("wake pin input buffer off");
  a_bus_wait: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("answer not after one wait state");
endmodule // cio_port_asserts
bind cio_port cio_port_asserts cio_port_asserts_i (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pad_in_i(pad_in_i), .pad_pd_o(pad_pd_o), .pad_spu_o(pad_spu_o),
  .pad_wpu_o(pad_wpu_o), .pad_vwpu_o(pad_vwpu_o), .pad_ibuf_en_o(pad_ibuf_en_o)
);
`default_nettype wire

//--- dv/tb_cio_port.sv
`default_nettype none
module tb_cio_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i, rst_i, ce_i, fuse, psel, pen, pwr, perr, prdy, xact, xdrv;
  logic [9:0] paddr;
  logic [31:0] pwd, prd;
  logic [7:0] xp0, xp2;
  logic [2:0] ten, ttg;
  logic [39:0] pin, pd, spu, wpu, vwpu, ibuf, alt_o, alt_in, ext_en, ext_val;
  int errors, num_checks, cnt;
  logic [43:0] rows [17] = '{
    {2'b00, 10'h304, 32'h03}, {2'b10, 10'h304, 32'h1b}, {2'b00, 10'h304, 32'h1b},
    {2'b10, 10'h000, 32'h0f}, {2'b10, 10'h004, 32'ha5}, {2'b10, 10'h008, 32'h00},
    {2'b10, 10'h010, 32'h0f}, {2'b10, 10'h040, 32'h48}, {2'b10, 10'h040, 32'h89},
    {2'b10, 10'h040, 32'h0b}, {2'b10, 10'h040, 32'hcf}, {2'b10, 10'h040, 32'h1c8},
    {2'b00, 10'h004, 32'h2f}, {2'b00, 10'h040, 32'h0}, {2'b01, 10'h3fc, 32'h0},
    {2'b01, 10'h002, 32'h0}, {2'b11, 10'h3f0, 32'h5a}};
  always #2.5 core_clk_i = ~core_clk_i;
  cio_port cio_port_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .tristate_fuse_i(fuse),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd),
    .pready_o(prdy), .pslverr_o(perr), .pad_in_i(pin), .pad_pd_o(pd), .pad_spu_o(spu), .pad_wpu_o(wpu),
    .pad_vwpu_o(vwpu), .pad_ibuf_en_o(ibuf), .alt_out_i(alt_o), .alt_in_o(alt_in), .tmr_out_en_i(ten),
    .tmr_toggle_i(ttg), .xmem_active_i(xact), .xmem_p0_drive_i(xdrv), .xmem_p0_out_i(xp0),
    .xmem_p2_out_i(xp2));
  cio_board cio_board_i (.core_clk_i(core_clk_i), .pd_i(pd), .pu_i(spu | wpu | vwpu),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(pin));
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic err);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwd <= d;
    @(posedge core_clk_i);
    pen <= 1'b1;
    do @(posedge core_clk_i); while (prdy !== 1'b1 && ++n < 50);
    if (n >= 50) errors++;
    if (!wr) chk({8'h0, prd}, {8'h0, d});
    chk({39'h0, perr}, {39'h0, err});
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic do_reset(input logic f, input int n);
    rst_i <= 1'b1;
    fuse <= f;
    repeat (n) @(posedge core_clk_i);
    rst_i <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    errors++;
    finish_test();
  end
  initial begin
    core_clk_i = 0; rst_i = 1; ce_i = 1; fuse = 0; psel = 0; pen = 0; pwr = 0; paddr = 0; pwd = 0;
    xact = 0; xdrv = 0; xp0 = 0; xp2 = 0; ten = 0; ttg = 0; alt_o = '1; errors = 0; num_checks = 0;
    ext_en = 40'h00_01ff_0000; ext_val = 40'h00_00a5_0000;
    @(posedge core_clk_i);
    do_reset(1'b0, 20);
    // modes: port3 quasi, port2 input, port1 push-pull, port0 open-drain
    foreach (rows[i]) bus(rows[i][43], rows[i][41:32], rows[i][31:0], rows[i][42]);
    $display("test rows done");
    repeat (6) @(posedge core_clk_i);
    chk(pd, 40'h30_0000_d0f0);
    chk(spu, 40'h00_0000_2f00);
    chk(vwpu, 40'h0f_ff00_0000);
    chk(wpu, 40'h0f_fe00_0000);
    chk(alt_in & 40'h3f_ffff_ff00, 40'h0f_fea5_2f00);
    bus(1'b0, 10'h02c, 32'hfe, 1'b0);
    bus(1'b0, 10'h00c, 32'hff, 1'b0);
    alt_o <= ~(40'h1 << 13);
    repeat (3) @(posedge core_clk_i);
    chk(pd, 40'h30_0000_f0f0);
    chk(spu, 40'h00_0000_0f00);
    alt_o <= '1;
    $display("test pads done");
    bus(1'b1, 10'h00c, 32'h00, 1'b0);
    bus(1'b1, 10'h00c, 32'hff, 1'b0);
    cnt = 0;
    repeat (4) begin
      @(posedge core_clk_i);
      if (spu[31:24] === 8'hff) cnt++;
    end
    chk(40'(cnt), 40'h1);
    bus(1'b1, 10'h010, 32'hff, 1'b0);
    bus(1'b1, 10'h010, 32'h0f, 1'b0);
    bus(1'b1, 10'h044, 32'h2, 1'b0);
    repeat (3) @(posedge core_clk_i);
    chk({34'h0, vwpu[37:32]}, 40'h0f);
    chk({38'h0, pd[39:38]}, 40'h3);
    bus(1'b1, 10'h044, 32'h3, 1'b0);
    repeat (3) @(posedge core_clk_i);
    chk(ibuf, 40'hc0_0c00_0000);
    bus(1'b0, 10'h02c, 32'h0c, 1'b0);
    bus(1'b1, 10'h044, 32'h2, 1'b0);
    $display("test strong pull-up and power-down done");
    ten <= 3'b111;
    @(posedge core_clk_i);
    ttg <= 3'b111;
    @(posedge core_clk_i);
    ttg <= 3'b000;
    bus(1'b0, 10'h00c, 32'hcf, 1'b0);
    bus(1'b0, 10'h004, 32'h2e, 1'b0);
    xact <= 1'b1;
    xdrv <= 1'b1;
    xp0 <= 8'h3c;
    xp2 <= 8'hc3;
    repeat (3) @(posedge core_clk_i);
    chk({24'h0, spu[23:16], spu[7:0]}, 40'hc33c);
    chk({24'h0, pd[23:16], pd[7:0]}, 40'h3cc3);
    xact <= 1'b0;
    $display("test timer and external memory done");
    do_reset(1'b1, 3);
    bus(1'b0, 10'h304, 32'h55, 1'b0);
    bus(1'b0, 10'h000, 32'hff, 1'b0);
    chk({8'h0, vwpu[31:0] | spu[31:0] | pd[31:0]}, 40'h0);
    $display("test fuse reset done");
    finish_test();
  end
endmodule // tb_cio_port
`default_nettype wire

//--- include/cio_consts.vh
`ifndef CIO_CONSTS_VH
`define CIO_CONSTS_VH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define CIO_ADDR_W        10
`define CIO_NPIN          40
`define CIO_NPORT_MODE    4

// ----------------------------------------
// register indices (byte address is 4x)
// ----------------------------------------
`define CIO_IDX_LATCH0    8'h00
`define CIO_IDX_LATCH4    8'h04
`define CIO_IDX_PIN0      8'h08
`define CIO_IDX_PIN4      8'h0c
`define CIO_IDX_BITOP     8'h10
`define CIO_IDX_CTRL      8'h11
`define CIO_IDX_MODE      8'hc1

// ----------------------------------------
// mode codes {high bit, low bit}
// ----------------------------------------
`define CIO_MODE_QUASI    2'b00
`define CIO_MODE_IN       2'b01
`define CIO_MODE_PP       2'b10
`define CIO_MODE_OD       2'b11

// ----------------------------------------
// reset values
// ----------------------------------------
`define CIO_MODE_RST      8'h03
`define CIO_MODE_RST_TRI  8'h55
`define CIO_LATCH_RST     40'hff_ffff_ffff
`define CIO_CTRL_RST      2'h0

// ----------------------------------------
// field positions
// ----------------------------------------
`define CIO_CTRL_PDOWN    0
`define CIO_CTRL_RCOSC    1
`define CIO_BITOP_BIT     2:0
`define CIO_BITOP_PORT    5:3
`define CIO_BITOP_OP      7:6
`define CIO_BITOP_VAL     8
`define CIO_BITOP_SET     2'h0
`define CIO_BITOP_CLR     2'h1
`define CIO_BITOP_CPL     2'h2
`define CIO_BITOP_MOV     2'h3
`define CIO_PORT_LAST     3'h4

// ----------------------------------------
// special pin positions (port*8+bit)
// ----------------------------------------
`define CIO_PIN_T2        8
`define CIO_PIN_IRQ0      26
`define CIO_PIN_IRQ1      27
`define CIO_PIN_T0        28
`define CIO_PIN_T1        29
`define CIO_PIN_XT1       38
`define CIO_PIN_XT2       39
`define CIO_TMR_T0        0
`define CIO_TMR_T1        1
`define CIO_TMR_T2        2

`endif

//--- verilog/cio_pin_cell.v
`include "cio_consts.vh"
`default_nettype none

// ----------------------------------------
// per-pin driver decode, registered
// ----------------------------------------
module cio_pin_cell (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       ce_i,
  input  wire [1:0] mode_i,
  input  wire       dout_i,
  input  wire       pin_i,
  output reg        pd_o,
  output reg        spu_o,
  output reg        wpu_o,
  output reg        vwpu_o
);

  reg dprev_q;
  reg pd_d;
  reg spu_d;
  reg wpu_d;
  reg vwpu_d;

  always @* begin
    pd_d   = 1'b0;
    spu_d  = 1'b0;
    wpu_d  = 1'b0;
    vwpu_d = 1'b0;
    case (mode_i)
      `CIO_MODE_QUASI: begin
        vwpu_d = dout_i;
        wpu_d  = dout_i & pin_i;
        spu_d  = dout_i & ~dprev_q;
        pd_d   = ~dout_i;
      end
      `CIO_MODE_PP: begin
        spu_d = dout_i;
        pd_d  = ~dout_i;
      end
      `CIO_MODE_OD: begin
        pd_d = ~dout_i;
      end
      `CIO_MODE_IN: begin
        pd_d = 1'b0;
      end
      default: begin
        pd_d = 1'b0;
      end
    endcase
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      dprev_q <= 1'b1;
      pd_o    <= 1'b0;
      spu_o   <= 1'b0;
      wpu_o   <= 1'b0;
      vwpu_o  <= 1'b0;
    end else if (ce_i) begin
      dprev_q <= dout_i;
      pd_o    <= pd_d;
      spu_o   <= spu_d;
      wpu_o   <= wpu_d;
      vwpu_o  <= vwpu_d;
    end
  end

endmodule // cio_pin_cell

`default_nettype wire

//--- verilog/cio_port.v
//
// Contract
// - one drive mode per 8-bit port, common to its eight pins.
// - mode pair low bit first: 00 quasi, 01 push-pull, 10 input, 11 open-drain.
// - modes in one byte register; port three 7:6 down to port zero 1:0.
// - reset: fuse set gives ports zero to three input-only, else quasi with port zero open-drain.
// - port four is quasi-bidirectional, except oscillator pins, which are input-only without internal RC oscillator.
// - power-down disables input buffers except two irq pins and oscillator pins.
// - quasi: very weak pull-up on whenever latch bit is one.
// - quasi: weak pull-up only while latch and sensed pin are one.
// - quasi: latch rising gives strong pull-up for exactly one cycle.
// - latch zero drives strong pull-down in quasi, open-drain, push-pull.
// - input-only: all drivers and very weak pull-up off.
// - open-drain: no pull-ups, pull-down only while latch is zero.
// - push-pull: strong pull-up continuous while latch is one.
// - plain read returns pins; read-modify-write read returns latch.
// - bit operations read whole latch byte, change one bit, write back.
// - alternate functions are ANDed with the latch bit.
// - latch zero forces alternate function zero, except input-only inputs.
// - external memory drives port zero and two, ignoring their modes.
// - timer clock outputs toggle the latch bits of their pins.
// - oscillator pins become general I/O only with internal RC oscillator.
//
// Register access over APB was left to the implementer.
`include "cio_consts.vh"
`default_nettype none

module cio_port (
  input  wire                   core_clk_i,
  input  wire                   rst_i,
  input  wire                   ce_i,
  input  wire                   tristate_fuse_i,
  // apb slave
  input  wire                   psel_i,
  input  wire                   penable_i,
  input  wire                   pwrite_i,
  input  wire [`CIO_ADDR_W-1:0] paddr_i,
  input  wire [31:0]            pwdata_i,
  output reg  [31:0]            prdata_o,
  output reg                    pready_o,
  output reg                    pslverr_o,
  // pads
  input  wire [`CIO_NPIN-1:0]   pad_in_i,
  output wire [`CIO_NPIN-1:0]   pad_pd_o,
  output wire [`CIO_NPIN-1:0]   pad_spu_o,
  output wire [`CIO_NPIN-1:0]   pad_wpu_o,
  output wire [`CIO_NPIN-1:0]   pad_vwpu_o,
  output reg  [`CIO_NPIN-1:0]   pad_ibuf_en_o,
  // peripherals
  input  wire [`CIO_NPIN-1:0]   alt_out_i,
  output reg  [`CIO_NPIN-1:0]   alt_in_o,
  input  wire [2:0]             tmr_out_en_i,
  input  wire [2:0]             tmr_toggle_i,
  // external memory
  input  wire                   xmem_active_i,
  input  wire                   xmem_p0_drive_i,
  input  wire [7:0]             xmem_p0_out_i,
  input  wire [7:0]             xmem_p2_out_i
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0]           mode_q;
  reg  [7:0]           mode_d;
  reg  [`CIO_NPIN-1:0] latch_q;
  reg  [`CIO_NPIN-1:0] latch_d;
  reg  [1:0]           ctrl_q;
  reg  [1:0]           ctrl_d;
  reg  [31:0]          rd_data;
  reg                  hit;
  wire [`CIO_NPIN-1:0] pin_sync;
  wire [`CIO_NPIN-1:0] pin_val;
  wire [`CIO_NPIN-1:0] ibuf_en;
  wire [`CIO_NPIN-1:0] in_only;
  wire [`CIO_NPIN-1:0] pin_dout;
  wire [2*`CIO_NPIN-1:0] pin_mode;
  wire [7:0]           idx;
  wire                 aligned;
  wire                 access;
  wire                 wr_en;
  wire [2:0]           bop_port;
  wire [5:0]           bop_idx;
  wire [2:0]           lat_port;
  wire [2:0]           pin_port;
  wire [7:0]           lat_off;
  wire [7:0]           pin_off;
  wire [`CIO_NPIN-1:0] tmr_flip;

  assign idx      = paddr_i[9:2];
  assign aligned  = (paddr_i[1:0] == 2'h0);
  assign access   = psel_i & penable_i;
  assign wr_en    = access & pready_o & pwrite_i & hit;
  assign bop_port = pwdata_i[`CIO_BITOP_PORT];
  assign bop_idx  = {bop_port, pwdata_i[`CIO_BITOP_BIT]};
  // port number within each register range
  assign lat_off  = idx - `CIO_IDX_LATCH0;
  assign pin_off  = idx - `CIO_IDX_PIN0;
  assign lat_port = lat_off[2:0];
  assign pin_port = pin_off[2:0];

  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  // two-flop sample
  cio_sync2 #(
    .W (`CIO_NPIN)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .ce_i       (ce_i),
    .d_i        (pad_in_i),
    .q_o        (pin_sync)
  );

  // ----------------------------------------
  // address decode and read mux
  // ----------------------------------------
  always @* begin
    hit     = 1'b0;
    rd_data = 32'h0000_0000;
    if (aligned) begin
      if (idx >= `CIO_IDX_LATCH0 && idx <= `CIO_IDX_LATCH4) begin
        hit = 1'b1;
        rd_data[7:0] = latch_q[{lat_port, 3'b000} +: 8];
      end else if (idx >= `CIO_IDX_PIN0 && idx <= `CIO_IDX_PIN4) begin
        hit = 1'b1;
        rd_data[7:0] = pin_val[{pin_port, 3'b000} +: 8];
      end else if (idx == `CIO_IDX_BITOP) begin
        hit = 1'b1;
      end else if (idx == `CIO_IDX_CTRL) begin
        hit = 1'b1;
        rd_data[1:0] = ctrl_q;
      end else if (idx == `CIO_IDX_MODE) begin
        hit = 1'b1;
        rd_data[7:0] = mode_q;
      end
    end
  end

  // ----------------------------------------
  // register next state
  // ----------------------------------------
  always @* begin
    mode_d  = mode_q;
    ctrl_d  = ctrl_q;
    latch_d = latch_q;
    if (wr_en) begin
      if (idx >= `CIO_IDX_LATCH0 && idx <= `CIO_IDX_LATCH4) begin
        latch_d[{lat_port, 3'b000} +: 8] = pwdata_i[7:0];
      end
      if (idx == `CIO_IDX_MODE) begin
        mode_d = pwdata_i[7:0];
      end
      if (idx == `CIO_IDX_CTRL) begin
        ctrl_d = pwdata_i[1:0];
      end
      if (idx == `CIO_IDX_BITOP && bop_port <= `CIO_PORT_LAST) begin
        case (pwdata_i[`CIO_BITOP_OP])
          `CIO_BITOP_SET: begin
            latch_d[bop_idx] = 1'b1;
          end
          `CIO_BITOP_CLR: begin
            latch_d[bop_idx] = 1'b0;
          end
          `CIO_BITOP_CPL: begin
            latch_d[bop_idx] = ~latch_q[bop_idx];
          end
          `CIO_BITOP_MOV: begin
            latch_d[bop_idx] = pwdata_i[`CIO_BITOP_VAL];
          end
          default: begin
            latch_d[bop_idx] = latch_q[bop_idx];
          end
        endcase
      end
    end
    latch_d = latch_d ^ tmr_flip;
  end

  // ----------------------------------------
  // registers and apb answer
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_q    <= tristate_fuse_i ? `CIO_MODE_RST_TRI : `CIO_MODE_RST;
      latch_q   <= `CIO_LATCH_RST;
      ctrl_q    <= `CIO_CTRL_RST;
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      mode_q  <= mode_d;
      latch_q <= latch_d;
      ctrl_q  <= ctrl_d;
      if (access & ~pready_o) begin
        pready_o  <= 1'b1;
        prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_data;
        pslverr_o <= ~hit;
      end else begin
        pready_o  <= 1'b0;
        pslverr_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // per-pin mode, data and drivers
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CIO_NPIN; g = g + 1) begin : g_pin
      localparam integer PORT = g / 8;
      wire [1:0] raw_mode;
      wire       osc_pin;
      wire       keep_buf;

      assign osc_pin  = (g == `CIO_PIN_XT1) || (g == `CIO_PIN_XT2);
      assign keep_buf = (g == `CIO_PIN_IRQ0) || (g == `CIO_PIN_IRQ1) || osc_pin;

      if (PORT < `CIO_NPORT_MODE) begin : g_moded
        assign raw_mode = mode_q[2*PORT +: 2];
      end else begin : g_quasi
        assign raw_mode = `CIO_MODE_QUASI;
      end

      if (PORT == 0) begin : g_p0
        assign pin_mode[2*g +: 2] = !xmem_active_i ? raw_mode :
                                    (xmem_p0_drive_i ? `CIO_MODE_PP : `CIO_MODE_IN);
        assign pin_dout[g] = xmem_active_i ? xmem_p0_out_i[g % 8] : (latch_q[g] & alt_out_i[g]);
      end else if (PORT == 2) begin : g_p2
        assign pin_mode[2*g +: 2] = xmem_active_i ? `CIO_MODE_PP : raw_mode;
        assign pin_dout[g] = xmem_active_i ? xmem_p2_out_i[g % 8] : (latch_q[g] & alt_out_i[g]);
      end else begin : g_px
        assign pin_mode[2*g +: 2] = (osc_pin && !ctrl_q[`CIO_CTRL_RCOSC]) ? `CIO_MODE_IN : raw_mode;
        assign pin_dout[g] = latch_q[g] & alt_out_i[g];
      end

      assign tmr_flip[g] = (g == `CIO_PIN_T0) ? (tmr_out_en_i[`CIO_TMR_T0] & tmr_toggle_i[`CIO_TMR_T0]) :
                           (g == `CIO_PIN_T1) ? (tmr_out_en_i[`CIO_TMR_T1] & tmr_toggle_i[`CIO_TMR_T1]) :
                           (g == `CIO_PIN_T2) ? (tmr_out_en_i[`CIO_TMR_T2] & tmr_toggle_i[`CIO_TMR_T2]) :
                           1'b0;

      assign in_only[g] = (pin_mode[2*g +: 2] == `CIO_MODE_IN);
      assign ibuf_en[g] = ~ctrl_q[`CIO_CTRL_PDOWN] | keep_buf;
      assign pin_val[g] = pin_sync[g] & ibuf_en[g];

      cio_pin_cell u_cell (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .ce_i       (ce_i),
        .mode_i     (pin_mode[2*g +: 2]),
        .dout_i     (pin_dout[g]),
        .pin_i      (pin_val[g]),
        .pd_o       (pad_pd_o[g]),
        .spu_o      (pad_spu_o[g]),
        .wpu_o      (pad_wpu_o[g]),
        .vwpu_o     (pad_vwpu_o[g])
      );
    end
  endgenerate

  // ----------------------------------------
  // alternate inputs and buffer enables
  // ----------------------------------------
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      alt_in_o      <= {`CIO_NPIN{1'b0}};
      pad_ibuf_en_o <= {`CIO_NPIN{1'b1}};
    end else if (ce_i) begin
      alt_in_o      <= pin_val & (latch_q | in_only);
      pad_ibuf_en_o <= ibuf_en;
    end
  end

endmodule // cio_port

`default_nettype wire

//--- verilog/cio_sync2.v
`default_nettype none

// ----------------------------------------
// two-flop input synchroniser
// ----------------------------------------
module cio_sync2 #(
  parameter W = 40
) (
  input  wire         core_clk_i,
  input  wire         ce_i,
  input  wire [W-1:0] d_i,
  output reg  [W-1:0] q_o
);

  reg [W-1:0] meta_q;

  always @(posedge core_clk_i) begin
    if (ce_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule // cio_sync2

`default_nettype wire
